/* core/odl_pkg.sv */
/*
 * Constants and types shared by the default configuration loader.
 * Assumes a single 25 MHz clock domain and an 8-bit register space with page select.
 */
package odl_pkg;

    // Register space: page select, loader flags and the mirror window on page 1.
    localparam logic [7:0] ODL_ADDR_PAGE_SEL    = 8'h77;
    localparam logic [7:0] ODL_ADDR_FLAGS       = 8'h7a;
    localparam logic [7:0] ODL_ADDR_SERIAL_CFG  = 8'ha0;
    localparam logic [7:0] ODL_ADDR_CONTROL_ONE = 8'ha1;
    localparam logic [7:0] ODL_ADDR_CONTROL_TWO = 8'ha2;
    localparam int         ODL_MIRROR_WORDS     = 3;
    localparam logic [2:0] ODL_PAGE_BASE        = 3'h0;
    localparam logic [2:0] ODL_PAGE_MIRROR      = 3'h1;

    // Flag register field positions.
    localparam int ODL_FLAG_TRIM    = 0;
    localparam int ODL_FLAG_FUSE    = 1;
    localparam int ODL_FLAG_STEST   = 2;
    localparam int ODL_STAT_LOADED  = 5;
    localparam int ODL_STAT_TRIAL   = 6;
    localparam int ODL_STAT_SRC_FSE = 7;

    // Hardwired default set and reset values.
    localparam logic [7:0] ODL_HW_SERIAL_CFG  = 8'h00;
    localparam logic [7:0] ODL_HW_CONTROL_ONE = 8'h02;
    localparam logic [7:0] ODL_HW_CONTROL_TWO = 8'h05;
    localparam logic [7:0] ODL_MIRROR_RESET   = 8'h00;
    localparam logic [7:0] ODL_TRIM_RESET     = 8'h00;
    localparam logic [6:0] ODL_TRIAL_I2C_ADDR = 7'h08;

    // Fuse word map: word 0 holds trim, words 1 to 3 the default set.
    localparam logic [1:0] ODL_FUSE_TRIM_IDX = 2'h0;
    localparam logic [1:0] ODL_FUSE_CFG_IDX  = 2'h1;
    localparam logic [1:0] ODL_FUSE_LAST_IDX = 2'h3;

    typedef enum logic [1:0] {
        ODL_ST_IDLE  = 2'b00,
        ODL_ST_FETCH = 2'b01,
        ODL_ST_COPY  = 2'b10
    } odl_state_t;

endpackage : odl_pkg

/* core/odl_fuse_fetch.sv */
/*
 * Reads a run of fuse words, one request at a time, and hands each word on.
 * Assumes the fuse array answers on the same clock with an ack or an error pulse.
 */
`timescale 1ns/10ps

module odl_fuse_fetch
    import odl_pkg::*;
(
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    input  wire logic       i_start,
    input  wire logic [1:0] i_first,
    input  wire logic [1:0] i_last,
    input  wire logic       i_fuse_ack,
    input  wire logic       i_fuse_err,
    input  wire logic [7:0] i_fuse_data,
    output logic            o_fuse_rd,
    output logic [1:0]      o_fuse_idx,
    output logic            o_word_vld,
    output logic [7:0]      o_word,
    output logic            o_done,
    output logic            o_err
);

    logic       busy;
    logic [1:0] last;

    // Steps through the fuse words and stops at the first error.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            busy       <= 1'b0;
            last       <= 2'h0;
            o_fuse_rd  <= 1'b0;
            o_fuse_idx <= 2'h0;
            o_word_vld <= 1'b0;
            o_word     <= 8'h00;
            o_done     <= 1'b0;
            o_err      <= 1'b0;
        end else begin
            o_word_vld <= 1'b0;
            o_done     <= 1'b0;
            if (!busy && i_start) begin
                busy       <= 1'b1;
                last       <= i_last;
                o_fuse_idx <= i_first;
                o_fuse_rd  <= 1'b1;
                o_err      <= 1'b0;
            end else if (busy && i_fuse_err) begin
                busy      <= 1'b0;
                o_fuse_rd <= 1'b0;
                o_done    <= 1'b1;
                o_err     <= 1'b1;
            end else if (busy && i_fuse_ack) begin
                o_word_vld <= 1'b1;
                o_word     <= i_fuse_data;
                if (o_fuse_idx == last) begin
                    busy      <= 1'b0;
                    o_fuse_rd <= 1'b0;
                    o_done    <= 1'b1;
                end else begin
                    o_fuse_idx <= o_fuse_idx + 2'h1;
                end
            end
        end
    end

endmodule : odl_fuse_fetch

/* core/odl_loader.sv */
/*
 * Default configuration loader: fuse or hardwired source, mirror registers,
 * trial and debug modes, sticky failure flags that gate power-up.
 * Assumes an I2C target on the same clock presents decoded register accesses,
 * a fuse array on the same clock, and i_rst asserted on undervoltage.
 */
// Contract
// - Source pin low selects mirror registers, high selects hardwired defaults.
// - Hardwired source copies hardwired defaults to functional registers on every reload.
// - Fuse source copies fuses into mirror on every supply rise through threshold.
// - Second stage copies mirror contents into functional registers.
// - Hardwired source forbids trial edits of the mirror registers.
// - Failures set flags; fuse source ignores power-up until cleared by writing 1 in off.
// - Failure flags are writable only with trial pin high, otherwise read only.
// - Trial mode ignores low-power-off default and goes to quiescent off.
// - Trial mode reports true self-test result, 0 pass, 1 fail.
// - Trial mode uses plain I2C, no CRC, no secure write.
// - Trial mode answers at address 0x08, ignoring fused address.
// - Trial mode disables watchdog input and internal watchdog timer.
// - Page 1 mirror access only in trial mode; extended pages refused otherwise.
// - Mirror preloads from fuses; host may overwrite in trial mode.
// - Power-up with trial pin high gives limited functionality.
// - Supply below threshold resets mirror, discarding trial configuration.
// - Fuse programming allowed only in trial mode while quiescent off.
// - Hardwired source still loads trim; trim failure sets trim flag.
// - Hardwired source with trial pin high enters debug mode like trial.
// - Hardwired source holds fuse-load failure flag at 0.
// - Hardwired source: flags block power-up until cleared by writing 0 in debug.
`timescale 1ns/10ps

module odl_loader
    import odl_pkg::*;
(
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    input  wire logic       i_src_sel_pin,
    input  wire logic       i_trial_en_pin,
    input  wire logic       i_supply_ok,
    input  wire logic       i_power_up_evt,
    input  wire logic       i_reload_req,
    input  wire logic       i_quiescent_off,
    input  wire logic       i_stest_done,
    input  wire logic       i_stest_fail,
    input  wire logic       i_reg_wr,
    input  wire logic       i_reg_rd,
    input  wire logic [7:0] i_reg_addr,
    input  wire logic [7:0] i_reg_wdata,
    input  wire logic       i_fuse_ack,
    input  wire logic       i_fuse_err,
    input  wire logic [7:0] i_fuse_data,
    output logic [7:0]      o_reg_rdata,
    output logic            o_reg_ack,
    output logic            o_reg_nack,
    output logic            o_fuse_rd,
    output logic [1:0]      o_fuse_idx,
    output logic [7:0]      o_trim,
    output logic [7:0]      o_serial_config,
    output logic [7:0]      o_control_one,
    output logic [7:0]      o_control_two,
    output logic            o_load_done,
    output logic            o_power_up_go,
    output logic            o_force_off_entry,
    output logic            o_i2c_addr_fixed,
    output logic [6:0]      o_i2c_fixed_addr,
    output logic            o_crc_off,
    output logic            o_secure_wr_off,
    output logic            o_watchdog_off,
    output logic            o_fuse_prog_allow
);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and derived modes.

    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic [2:0] pin_in;
    logic       src_fuse;
    logic       trial_pin;
    logic       supply_ok;
    logic       supply_prev;
    logic       supply_rise;
    logic       supply_fall;

    assign pin_in = {i_supply_ok, i_trial_en_pin, i_src_sel_pin};

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            always_ff @(posedge i_mclk or posedge i_rst) begin
                if (i_rst) begin
                    sync_a[g] <= 1'b0;
                    sync_b[g] <= 1'b0;
                end else begin
                    sync_a[g] <= pin_in[g];
                    sync_b[g] <= sync_a[g];
                end
            end
        end
    endgenerate

    assign src_fuse    = !sync_b[0];
    assign trial_pin   = sync_b[1];
    assign supply_ok   = sync_b[2];
    assign supply_rise = supply_ok && !supply_prev;
    assign supply_fall = !supply_ok && supply_prev;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            supply_prev <= 1'b0;
        end else begin
            supply_prev <= supply_ok;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register decode.

    logic [2:0] page;
    logic [7:0] mirror [ODL_MIRROR_WORDS];
    logic [2:0] flags;
    logic       loaded;
    logic       acc;
    logic       ext_refused;
    logic [2:0] mir_dec;
    logic       mirror_wr;
    logic       flags_wr;

    function automatic logic [2:0] mirror_sel(input logic [7:0] addr);
        logic [2:0] r;
        r = 3'h0;
        if (addr == ODL_ADDR_SERIAL_CFG) begin
            r = 3'h4;
        end else if (addr == ODL_ADDR_CONTROL_ONE) begin
            r = 3'h5;
        end else if (addr == ODL_ADDR_CONTROL_TWO) begin
            r = 3'h6;
        end
        return r;
    endfunction : mirror_sel

    assign acc         = i_reg_wr || i_reg_rd;
    assign ext_refused = acc && (page != ODL_PAGE_BASE) && !trial_pin;
    assign mir_dec     = mirror_sel(i_reg_addr);
    assign mirror_wr   = i_reg_wr && trial_pin && src_fuse && (page == ODL_PAGE_MIRROR)
                         && mir_dec[2];
    assign flags_wr    = i_reg_wr && (page == ODL_PAGE_BASE) && (i_reg_addr == ODL_ADDR_FLAGS);

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            page <= ODL_PAGE_BASE;
        end else if (i_reg_wr && (i_reg_addr == ODL_ADDR_PAGE_SEL)) begin
            page <= i_reg_wdata[2:0];
        end
    end

    // Answers one cycle after the access; refused accesses return zero.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_reg_ack   <= 1'b0;
            o_reg_nack  <= 1'b0;
            o_reg_rdata <= 8'h00;
        end else begin
            o_reg_ack   <= acc && !ext_refused;
            o_reg_nack  <= ext_refused || (acc && (page == ODL_PAGE_MIRROR) && !src_fuse);
            o_reg_rdata <= 8'h00;
            if (i_reg_rd && !ext_refused) begin
                if (i_reg_addr == ODL_ADDR_PAGE_SEL) begin
                    o_reg_rdata <= {5'h00, page};
                end else if ((page == ODL_PAGE_BASE) && (i_reg_addr == ODL_ADDR_FLAGS)) begin
                    o_reg_rdata <= {src_fuse, trial_pin, loaded, 2'b00, flags};
                end else if ((page == ODL_PAGE_MIRROR) && src_fuse && mir_dec[2]) begin
                    o_reg_rdata <= mirror[mir_dec[1:0]];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Loading sequence.

    odl_state_t state;
    logic       fetch_start;
    logic       fetch_vld;
    logic [7:0] fetch_word;
    logic       fetch_done;
    logic       fetch_err;
    logic [1:0] word_idx;

    assign fetch_start = (state == ODL_ST_IDLE) && supply_rise;

    odl_fuse_fetch u_fetch (
        .i_mclk      (i_mclk),
        .i_rst       (i_rst),
        .i_start     (fetch_start),
        .i_first     (ODL_FUSE_TRIM_IDX),
        .i_last      (src_fuse ? ODL_FUSE_LAST_IDX : ODL_FUSE_TRIM_IDX),
        .i_fuse_ack  (i_fuse_ack),
        .i_fuse_err  (i_fuse_err),
        .i_fuse_data (i_fuse_data),
        .o_fuse_rd   (o_fuse_rd),
        .o_fuse_idx  (o_fuse_idx),
        .o_word_vld  (fetch_vld),
        .o_word      (fetch_word),
        .o_done      (fetch_done),
        .o_err       (fetch_err)
    );

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            word_idx <= 2'h0;
        end else if (fetch_start) begin
            word_idx <= ODL_FUSE_TRIM_IDX;
        end else if (fetch_vld) begin
            word_idx <= word_idx + 2'h1;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            state <= ODL_ST_IDLE;
        end else begin
            case (state)
                ODL_ST_IDLE: begin
                    if (supply_rise) begin
                        state <= ODL_ST_FETCH;
                    end else if (i_reload_req && loaded) begin
                        state <= ODL_ST_COPY;
                    end
                end
                ODL_ST_FETCH: begin
                    if (fetch_done) begin
                        state <= ODL_ST_COPY;
                    end
                end
                ODL_ST_COPY: begin
                    state <= ODL_ST_IDLE;
                end
                default: begin
                    state <= ODL_ST_IDLE;
                end
            endcase
        end
    end

    // Mirror: cleared on supply loss, filled from fuses, edited in trial mode.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            for (int i = 0; i < ODL_MIRROR_WORDS; i++) begin
                mirror[i] <= ODL_MIRROR_RESET;
            end
        end else if (supply_fall) begin
            for (int i = 0; i < ODL_MIRROR_WORDS; i++) begin
                mirror[i] <= ODL_MIRROR_RESET;
            end
        end else if (fetch_vld && (word_idx >= ODL_FUSE_CFG_IDX)) begin
            mirror[word_idx - ODL_FUSE_CFG_IDX] <= fetch_word;
        end else if (mirror_wr) begin
            mirror[mir_dec[1:0]] <= i_reg_wdata;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_trim <= ODL_TRIM_RESET;
        end else if (fetch_vld && (word_idx == ODL_FUSE_TRIM_IDX)) begin
            o_trim <= fetch_word;
        end
    end

    // Functional registers take mirror or hardwired set in the copy stage.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_serial_config <= ODL_HW_SERIAL_CFG;
            o_control_one   <= ODL_HW_CONTROL_ONE;
            o_control_two   <= ODL_HW_CONTROL_TWO;
            o_load_done     <= 1'b0;
            loaded          <= 1'b0;
        end else begin
            o_load_done <= 1'b0;
            if (state == ODL_ST_COPY) begin
                o_load_done <= 1'b1;
                loaded      <= 1'b1;
                if (src_fuse) begin
                    o_serial_config <= mirror[0];
                    o_control_one   <= mirror[1];
                    o_control_two   <= mirror[2];
                end else begin
                    o_serial_config <= ODL_HW_SERIAL_CFG;
                    o_control_one   <= ODL_HW_CONTROL_ONE;
                    o_control_two   <= ODL_HW_CONTROL_TWO;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Failure flags: set wins over clear.

    logic [2:0] next_flags;
    logic [2:0] set_flags;
    logic [2:0] clr_flags;
    logic       clr_allowed;

    always_comb begin
        set_flags = 3'h0;
        if (fetch_done && fetch_err) begin
            if (word_idx == ODL_FUSE_TRIM_IDX) begin
                set_flags[ODL_FLAG_TRIM] = 1'b1;
            end else begin
                set_flags[ODL_FLAG_FUSE] = 1'b1;
            end
        end
        if (i_stest_done && i_stest_fail) begin
            set_flags[ODL_FLAG_STEST] = 1'b1;
        end
    end

    assign clr_allowed = flags_wr && trial_pin && (!src_fuse || i_quiescent_off);

    always_comb begin
        clr_flags = 3'h0;
        if (clr_allowed) begin
            clr_flags = src_fuse ? i_reg_wdata[2:0] : ~i_reg_wdata[2:0];
        end
        if (i_stest_done && !i_stest_fail && trial_pin) begin
            clr_flags[ODL_FLAG_STEST] = 1'b1;
        end
        next_flags = (flags & ~clr_flags) | set_flags;
        if (!src_fuse) begin
            next_flags[ODL_FLAG_FUSE] = 1'b0;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            flags <= 3'h0;
        end else begin
            flags <= next_flags;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Power-up gating and limited functionality.

    logic limited_latch;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_power_up_go <= 1'b0;
            limited_latch <= 1'b0;
        end else begin
            o_power_up_go <= i_power_up_evt && loaded && (flags == 3'h0);
            if (i_power_up_evt && loaded && (flags == 3'h0)) begin
                limited_latch <= trial_pin;
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_force_off_entry <= 1'b0;
            o_i2c_addr_fixed  <= 1'b0;
            o_i2c_fixed_addr  <= ODL_TRIAL_I2C_ADDR;
            o_crc_off         <= 1'b0;
            o_secure_wr_off   <= 1'b0;
            o_watchdog_off    <= 1'b0;
            o_fuse_prog_allow <= 1'b0;
        end else begin
            o_force_off_entry <= trial_pin;
            o_i2c_addr_fixed  <= trial_pin || limited_latch;
            o_i2c_fixed_addr  <= ODL_TRIAL_I2C_ADDR;
            o_crc_off         <= trial_pin || limited_latch;
            o_secure_wr_off   <= trial_pin || limited_latch;
            o_watchdog_off    <= trial_pin || limited_latch;
            o_fuse_prog_allow <= trial_pin && src_fuse && i_quiescent_off;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    chk_power_up_event_blocked: assert property ((flags != 3'h0) |=> !o_power_up_go)
        else $error("Power-up granted with a failure flag set.");
    chk_power_up_event_granted: assert property (i_power_up_evt && loaded && (flags == 3'h0) |=> o_power_up_go)
        else $error("Clean power-up event not granted.");
    chk_hw_fuse_zero: assert property (!src_fuse && $past(!src_fuse) |-> !flags[ODL_FLAG_FUSE])
        else $error("Fuse failure flag set under hardwired source.");
    chk_ext_page_ref: assert property (ext_refused |=> o_reg_nack && !o_reg_ack)
        else $error("Extended page access not refused.");
    chk_mirror_locked: assert property (i_reg_wr && !src_fuse && !fetch_vld && !supply_fall
                                        |=> $stable(mirror[0]) && $stable(mirror[1]) && $stable(mirror[2]))
        else $error("Mirror changed by a write under hardwired source.");
    chk_stest_report: assert property (i_stest_done && trial_pin |=> flags[ODL_FLAG_STEST] == $past(i_stest_fail))
        else $error("Self-test flag does not match the result.");
    chk_hw_copy_set: assert property ((state == ODL_ST_COPY) && !src_fuse
                                      |=> o_serial_config == ODL_HW_SERIAL_CFG && o_control_one == ODL_HW_CONTROL_ONE
                                          && o_control_two == ODL_HW_CONTROL_TWO && o_load_done)
        else $error("Hardwired copy stage did not load the hardwired set.");
    chk_supply_fetch: assert property ((state == ODL_ST_IDLE) && supply_rise |=> state == ODL_ST_FETCH ##1 o_fuse_rd)
        else $error("Supply rise did not start a fuse fetch.");
    chk_mirror_clear: assert property (supply_fall |=> mirror[0] == ODL_MIRROR_RESET && mirror[2] == ODL_MIRROR_RESET)
        else $error("Mirror not cleared on supply loss.");
    chk_trial_limits: assert property (trial_pin |=> o_watchdog_off && o_crc_off && o_i2c_addr_fixed)
        else $error("Trial mode did not restrict functions.");

endmodule : odl_loader

/* testbench/odl_fuse_model.sv */
/* Fuse array model for the loader's fuse read port.
 * Assumes the loader holds its read request and index until an ack or error. */
`timescale 1ns/10ps

module odl_fuse_model (
    input  wire logic        i_mclk,
    input  wire logic        i_rd,
    input  wire logic [1:0]  i_idx,
    input  wire logic [31:0] i_words,
    input  wire logic [3:0]  i_err_mask,
    output logic             o_ack,
    output logic             o_err,
    output logic [7:0]       o_data
);
    logic [1:0] wait_cnt;

    initial begin
        o_ack = 1'b0;
        o_err = 1'b0;
        o_data = 8'h00;
        wait_cnt = 2'h0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Word N answers after N idle cycles; data toggles when not answering.
    always @(posedge i_mclk) begin
        o_ack <= 1'b0;
        o_err <= 1'b0;
        o_data <= ~o_data;
        if (i_rd && !o_ack && !o_err) begin
            if (wait_cnt == i_idx) begin
                wait_cnt <= 2'h0;
                o_ack <= !i_err_mask[i_idx];
                o_err <= i_err_mask[i_idx];
                o_data <= i_words[i_idx*8 +: 8];
            end else begin
                wait_cnt <= wait_cnt + 2'h1;
            end
        end
    end
endmodule : odl_fuse_model

/* testbench/tb.sv */
/* Self-checking bench for the default configuration loader.
 * Assumes odl_loader as top with the fuse model on its fuse port. */
`timescale 1ns/10ps

module tb;
    import odl_pkg::*;
    logic       i_mclk = 0, i_rst = 1, i_src_sel_pin = 0, i_trial_en_pin = 0, i_supply_ok = 0;
    logic       i_power_up_evt = 0, i_reload_req = 0, i_quiescent_off = 0, i_stest_done = 0;
    logic       i_stest_fail = 0, i_reg_wr = 0, i_reg_rd = 0, i_fuse_ack, i_fuse_err, nk, ak;
    logic [7:0] i_reg_addr = 0, i_reg_wdata = 0, i_fuse_data, o_reg_rdata, o_trim, q;
    logic [7:0] o_serial_config, o_control_one, o_control_two;
    logic       o_reg_ack, o_reg_nack, o_fuse_rd, o_load_done, o_power_up_go, o_force_off_entry;
    logic       o_i2c_addr_fixed, o_crc_off, o_secure_wr_off, o_watchdog_off, o_fuse_prog_allow;
    logic [1:0] o_fuse_idx;
    logic [6:0] o_i2c_fixed_addr;
    logic [3:0] err_mask = 0;
    int         miscompares = 0, cmp_count = 0;

    odl_loader u_dut (.*);
    odl_fuse_model u_fuse (.i_mclk(i_mclk), .i_rd(o_fuse_rd), .i_idx(o_fuse_idx), .i_words(32'h5ac3963c),
                           .i_err_mask(err_mask), .o_ack(i_fuse_ack), .o_err(i_fuse_err), .o_data(i_fuse_data));

    always #20 i_mclk = ~i_mclk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask : cyc

    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        i_reg_wr = w;
        i_reg_rd = !w;
        i_reg_addr = a;
        i_reg_wdata = d;
        cyc(1);
        i_reg_wr = 1'b0;
        i_reg_rd = 1'b0;
        q = o_reg_rdata;
        nk = o_reg_nack;
        ak = o_reg_ack;
        cyc(1);
    endtask : acc

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        acc(1'b0, a, 8'h00);
        chk(q, e);
    endtask : rd

    task automatic pulse(ref logic s);
        s = 1'b1;
        cyc(1);
        s = 1'b0;
    endtask : pulse

    task automatic wait_done();
        int n;
        n = 0;
        while (o_load_done !== 1'b1 && n < 80) begin
            cyc(1);
            n++;
        end
        chk(8'(n < 80), 8'h01);
    endtask : wait_done

    task automatic boot(input logic src, input logic [3:0] em);
        i_rst = 1'b1;
        i_supply_ok = 1'b0;
        i_src_sel_pin = src;
        err_mask = em;
        cyc(12);
        i_rst = 1'b0;
        cyc(3);
        i_supply_ok = 1'b1;
        wait_done();
    endtask : boot

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_fuse();
        boot(1'b0, 4'h0);
        chk(o_trim, 8'h3c);
        chk(o_serial_config, 8'h96);
        chk(o_control_one, 8'hc3);
        chk(o_control_two, 8'h5a);
        rd(ODL_ADDR_FLAGS, 8'ha0);
        chk({6'h0, ak, nk}, 8'h02);
        wr(ODL_ADDR_PAGE_SEL, 8'h01);
        rd(ODL_ADDR_SERIAL_CFG, 8'h00);
        chk({6'h0, ak, nk}, 8'h01);
        wr(ODL_ADDR_PAGE_SEL, 8'h00);
        $display("test fuse load finished");
    endtask : t_fuse

    task automatic t_trial();
        i_trial_en_pin = 1'b1;
        cyc(3);
        chk({o_force_off_entry, o_crc_off, o_secure_wr_off, o_watchdog_off, 4'h0}, 8'hf0);
        chk({o_i2c_addr_fixed, o_i2c_fixed_addr}, 8'h88);
        wr(ODL_ADDR_PAGE_SEL, 8'h01);
        rd(ODL_ADDR_SERIAL_CFG, 8'h96);
        wr(ODL_ADDR_SERIAL_CFG, 8'h11);
        wr(ODL_ADDR_PAGE_SEL, 8'h00);
        pulse(i_reload_req);
        wait_done();
        chk(o_serial_config, 8'h11);
        i_quiescent_off = 1'b1;
        cyc(2);
        chk({7'h0, o_fuse_prog_allow}, 8'h01);
        i_quiescent_off = 1'b0;
        i_supply_ok = 1'b0;
        cyc(4);
        i_supply_ok = 1'b1;
        wait_done();
        chk(o_serial_config, 8'h96);
        $display("test trial mode finished");
    endtask : t_trial

    task automatic t_flags();
        i_trial_en_pin = 1'b0;
        i_stest_fail = 1'b1;
        cyc(3);
        pulse(i_stest_done);
        rd(ODL_ADDR_FLAGS, 8'ha4);
        pulse(i_power_up_evt);
        chk({7'h0, o_power_up_go}, 8'h00);
        wr(ODL_ADDR_FLAGS, 8'h04);
        rd(ODL_ADDR_FLAGS, 8'ha4);
        i_trial_en_pin = 1'b1;
        i_quiescent_off = 1'b1;
        cyc(3);
        wr(ODL_ADDR_FLAGS, 8'h04);
        rd(ODL_ADDR_FLAGS, 8'he0);
        pulse(i_power_up_evt);
        chk({7'h0, o_power_up_go}, 8'h01);
        i_trial_en_pin = 1'b0;
        i_quiescent_off = 1'b0;
        cyc(3);
        chk({7'h0, o_crc_off}, 8'h01);
        $display("test failure flags finished");
    endtask : t_flags

    task automatic t_hw();
        boot(1'b1, 4'h1);
        chk({o_serial_config ^ ODL_HW_SERIAL_CFG}, 8'h00);
        chk(o_control_one, 8'h02);
        chk(o_control_two, 8'h05);
        rd(ODL_ADDR_FLAGS, 8'h21);
        pulse(i_power_up_evt);
        chk({7'h0, o_power_up_go}, 8'h00);
        i_trial_en_pin = 1'b1;
        cyc(3);
        wr(ODL_ADDR_PAGE_SEL, 8'h01);
        rd(ODL_ADDR_SERIAL_CFG, 8'h00);
        chk({7'h0, nk}, 8'h01);
        wr(ODL_ADDR_PAGE_SEL, 8'h00);
        wr(ODL_ADDR_FLAGS, 8'h00);
        rd(ODL_ADDR_FLAGS, 8'h60);
        pulse(i_stest_done);
        rd(ODL_ADDR_FLAGS, 8'h64);
        i_stest_fail = 1'b0;
        pulse(i_stest_done);
        rd(ODL_ADDR_FLAGS, 8'h60);
        $display("test hardwired source finished");
    endtask : t_hw

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    initial begin
        t_fuse();
        t_trial();
        t_flags();
        t_hw();
        end_of_test();
    end

    initial begin
        #400000;
        miscompares++;
        $display("unexpected at %0t: watchdog expired", $time);
        end_of_test();
    end
endmodule : tb
